//--- logic/clock_unit_pkg.sv
package clock_unit_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Alternate clock counts as absent after this long without an edge.
  localparam int unsigned ALT_LOSS_NS = 100000;
  localparam int unsigned ALT_LOSS_CYCLES_DEF = ALT_LOSS_NS / CLK_PERIOD_NS;
  localparam int unsigned ALT_CNT_W = 16;
  localparam int unsigned IRQ_LOW_NS = 40;
  localparam logic [2:0] IRQ_LOW_CYCLES = 3'(IRQ_LOW_NS / CLK_PERIOD_NS);
  localparam int unsigned REF_CNT_W = 16;
  localparam int unsigned PLL_ACC_W = 20;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] MODE_ADDR = 8'hEB;
  localparam logic [7:0] CTL_ADDR = 8'hF0;
  localparam logic [7:0] FLAG_ADDR = 8'hF2;
  localparam logic [7:0] PLLCFG_ADDR = 8'hF6;

  localparam logic [7:0] MODE_RESET = 8'hE0;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [2:0] POSTDIV_OFF = 3'h7;
  localparam logic [1:0] MULT_RESET = 2'h0;

  // Mode register fields.
  localparam int unsigned MODE_HALVER_BIT = 5;
  localparam int unsigned MODE_PRS_MSB = 4;
  localparam int unsigned MODE_PRS_LSB = 2;
  // Clock control register fields.
  localparam int unsigned CTL_INTSEL_BIT = 7;
  localparam int unsigned CTL_ALTSEL_BIT = 2;
  localparam int unsigned CTL_WAITALT_BIT = 1;
  localparam int unsigned CTL_LPWAIT_BIT = 0;
  localparam logic [7:0] CTL_WR_MASK = 8'h87;
  // Clock flag register fields.
  localparam int unsigned FLAG_XSTOP_BIT = 4;
  localparam int unsigned FLAG_SLOWDIV_BIT = 3;
  localparam int unsigned FLAG_ALTACT_BIT = 2;
  localparam int unsigned FLAG_PLLSRC_BIT = 0;
  // PLL configuration register fields.
  localparam int unsigned PLL_MULT_MSB = 5;
  localparam int unsigned PLL_MULT_LSB = 4;
  localparam int unsigned PLL_DIV_MSB = 2;
  localparam int unsigned PLL_DIV_LSB = 0;

  // Multiplier codes.
  localparam logic [1:0] MULT_X14 = 2'h2;
  localparam logic [1:0] MULT_X10 = 2'h0;
  localparam logic [1:0] MULT_X8 = 2'h3;
  localparam logic [1:0] MULT_X6 = 2'h1;

  typedef enum logic [1:0] {SRC_REF, SRC_PLL, SRC_DIV16, SRC_ALT} sysSrc_t;

endpackage : clock_unit_pkg

//--- logic/pll_clock_control_unit.sv
module pll_clock_control_unit
  import clock_unit_pkg::*;
#(
  parameter int unsigned ALT_LOSS_CYCLES = ALT_LOSS_CYCLES_DEF
)
(
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [7:0] rdData,
  // Clock sources, one-cycle pulse per rising edge
  input wire logic oscTick,
  input wire logic altTick,
  // Core status
  input wire logic waitForInt,
  input wire logic memWait,
  input wire logic busReq,
  input wire logic extIrqPin,
  // Clock and control outputs
  output logic sysTick,
  output logic coreTick,
  output logic oscEnable,
  output logic pllOn,
  output logic irqLine
);

  // ----------------------------------------------------------------------
  // Registers and decode
  // ----------------------------------------------------------------------
  logic [7:0] modeReg;
  logic [7:0] ctlReg;
  logic stopReqReg;
  logic slowDivReg;
  logic pllSrcReg;
  logic [1:0] multReg;
  logic [2:0] postDivReg;
  sysSrc_t srcReg;
  sysSrc_t wantSrc;

  wire wrMode = wrStrobe && (addr == MODE_ADDR);
  wire wrCtl = wrStrobe && (addr == CTL_ADDR);
  wire wrFlag = wrStrobe && (addr == FLAG_ADDR);
  wire wrPll = wrStrobe && (addr == PLLCFG_ADDR);

  wire halver = modeReg[MODE_HALVER_BIT];
  wire [2:0] prescale = modeReg[MODE_PRS_MSB:MODE_PRS_LSB];
  wire intSel = ctlReg[CTL_INTSEL_BIT];
  wire lowPowerWait = waitForInt && ctlReg[CTL_LPWAIT_BIT];
  wire waitAltReq = lowPowerWait && ctlReg[CTL_WAITALT_BIT];
  wire altRequest = ctlReg[CTL_ALTSEL_BIT] || waitAltReq;
  wire altActive = (srcReg == SRC_ALT);
  // A written stop request only shows once the alternate clock runs.
  wire xtalStopFlag = stopReqReg && altActive;

  function automatic logic [3:0] multFactor(input logic [1:0] code);
    case (code)
      MULT_X14: multFactor = 4'hE;
      MULT_X10: multFactor = 4'hA;
      MULT_X8: multFactor = 4'h8;
      default: multFactor = 4'h6;
    endcase
  endfunction : multFactor

  // ----------------------------------------------------------------------
  // Oscillator, reference and slow clocks
  // ----------------------------------------------------------------------
  logic halfPhase;
  logic [3:0] div16Cnt;
  logic [ALT_CNT_W-1:0] altIdleCnt;

  wire oscStopped = altActive && (stopReqReg || waitAltReq);
  wire oscRun = oscTick && !oscStopped;
  wire refTick = halver ? (oscRun && halfPhase) : oscRun;
  wire div16Tick = refTick && (div16Cnt == 4'hF);
  wire altPresent = altIdleCnt < ALT_CNT_W'(ALT_LOSS_CYCLES);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      halfPhase <= 1'b0;
      div16Cnt <= 4'h0;
      altIdleCnt <= '1;
    end
    else if (ce)
    begin
      if (oscRun)
        halfPhase <= !halfPhase;
      if (refTick)
        div16Cnt <= div16Cnt + 4'h1;
      if (altTick)
        altIdleCnt <= '0;
      else if (altIdleCnt != '1)
        altIdleCnt <= altIdleCnt + ALT_CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------------
  // PLL model
  // ----------------------------------------------------------------------
  // PLL pulses come from a rate accumulator: the multiplier is added each
  // cycle against reference period times post-divide. Output is capped at
  // one pulse a cycle, so keep the reference period at 14 cycles or more.
  logic [REF_CNT_W-1:0] refCnt;
  logic [REF_CNT_W-1:0] refPeriod;
  logic [PLL_ACC_W-1:0] pllAcc;
  logic pllLocked;

  wire pllActive = (postDivReg != POSTDIV_OFF) && slowDivReg
                   && !lowPowerWait && !oscStopped;
  wire [PLL_ACC_W-1:0] pllThresh = PLL_ACC_W'(refPeriod)
                                   * PLL_ACC_W'({1'b0, postDivReg} + 4'h1);
  wire [PLL_ACC_W-1:0] pllSum = pllAcc + PLL_ACC_W'(multFactor(multReg));
  wire pllTick = pllActive && pllLocked && (pllSum >= pllThresh);

  always_ff @(posedge clk)
  begin
    if (!rst_n || (ce && !pllActive))
    begin
      refCnt <= '0;
      refPeriod <= '0;
      pllAcc <= '0;
      pllLocked <= 1'b0;
    end
    else if (ce)
    begin
      refCnt <= refTick ? REF_CNT_W'(1) : refCnt + REF_CNT_W'(1);
      if (refTick && refCnt != '0)
      begin
        refPeriod <= refCnt;
        pllLocked <= 1'b1;
      end
      pllAcc <= pllTick ? pllSum - pllThresh : pllSum;
    end
  end

  // ----------------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------------
  logic curTick;
  logic curAlive;

  always_comb
  begin
    if (altRequest && altPresent)
      wantSrc = SRC_ALT;
    else if (!slowDivReg || lowPowerWait)
      wantSrc = SRC_DIV16;
    else if (pllSrcReg && pllLocked)
      wantSrc = SRC_PLL;
    else
      wantSrc = SRC_REF;
  end

  always_comb
  begin
    case (srcReg)
      SRC_PLL:
      begin
        curTick = pllTick;
        curAlive = pllActive && pllLocked;
      end
      SRC_DIV16:
      begin
        curTick = div16Tick;
        curAlive = !oscStopped;
      end
      SRC_ALT:
      begin
        curTick = altTick;
        curAlive = altPresent;
      end
      default:
      begin
        curTick = refTick;
        curAlive = !oscStopped;
      end
    endcase
  end

  // Switch only at the end of a period of the running source, or at once
  // when it has died, so the running source's last period is never cut short.
  wire switchNow = (wantSrc != srcReg) && (curTick || !curAlive);
  wire srcIsSlow = (srcReg == SRC_ALT) || (srcReg == SRC_DIV16);
  wire wantIsSlow = (wantSrc == SRC_ALT) || (wantSrc == SRC_DIV16);
  wire srcEvent = switchNow && (srcIsSlow || wantIsSlow);

  // Hardware clear wins over a software set in the same cycle.
  wire pllSrcClear = (wrPll && wrData[PLL_DIV_MSB:PLL_DIV_LSB] == POSTDIV_OFF)
                     || oscStopped || lowPowerWait || !slowDivReg;

  // ----------------------------------------------------------------------
  // Core prescaler and outputs
  // ----------------------------------------------------------------------
  logic [2:0] prsCnt;
  logic [2:0] irqCnt;

  wire coreRun = !waitForInt && !memWait && !busReq;
  // The count restarts at each core edge; a new ratio at or below the count
  // ends the current core period at the next system tick.
  wire coreEdge = curTick && coreRun && (prsCnt >= prescale);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      srcReg <= SRC_REF;
      prsCnt <= 3'h0;
      irqCnt <= 3'h0;
      sysTick <= 1'b0;
      coreTick <= 1'b0;
      irqLine <= 1'b1;
    end
    else if (ce)
    begin
      if (switchNow)
        srcReg <= wantSrc;
      if (curTick && coreRun)
        prsCnt <= coreEdge ? 3'h0 : prsCnt + 3'h1;
      if (srcEvent)
        irqCnt <= IRQ_LOW_CYCLES;
      else if (irqCnt != 3'h0)
        irqCnt <= irqCnt - 3'h1;
      sysTick <= curTick;
      coreTick <= coreEdge;
      irqLine <= intSel ? (irqCnt == 3'h0) : extIrqPin;
    end
  end

  assign oscEnable = !oscStopped;
  assign pllOn = pllActive;

  // ----------------------------------------------------------------------
  // Register writes and reads
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      modeReg <= MODE_RESET;
      ctlReg <= CTL_RESET;
      stopReqReg <= 1'b0;
      slowDivReg <= 1'b1;
      pllSrcReg <= 1'b0;
      multReg <= MULT_RESET;
      postDivReg <= POSTDIV_OFF;
      rdData <= 8'h00;
    end
    else if (ce)
    begin
      if (wrMode)
        modeReg <= wrData;
      if (wrCtl)
        ctlReg <= wrData & CTL_WR_MASK;
      if (wrFlag)
      begin
        stopReqReg <= wrData[FLAG_XSTOP_BIT];
        slowDivReg <= wrData[FLAG_SLOWDIV_BIT];
      end
      if (pllSrcClear)
        pllSrcReg <= 1'b0;
      else if (wrFlag)
        pllSrcReg <= wrData[FLAG_PLLSRC_BIT];
      if (wrPll)
      begin
        multReg <= wrData[PLL_MULT_MSB:PLL_MULT_LSB];
        postDivReg <= wrData[PLL_DIV_MSB:PLL_DIV_LSB];
      end
      if (rdStrobe)
        case (addr)
          MODE_ADDR: rdData <= modeReg;
          CTL_ADDR: rdData <= ctlReg;
          FLAG_ADDR: rdData <= {3'h0, xtalStopFlag, slowDivReg, altActive,
                                1'b0, pllSrcReg};
          PLLCFG_ADDR: rdData <= {2'h0, multReg, 1'b0, postDivReg};
          default: rdData <= 8'h00;
        endcase
      else
        rdData <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_ref_direct;
    !halver |-> (refTick == oscRun);
  endproperty
  a_ref_direct: assert property (p_ref_direct)
    else $error("reference differs from oscillator with halver clear");
  property p_pll_off;
    (postDivReg == POSTDIV_OFF) |-> !pllOn && !pllTick;
  endproperty
  a_pll_off: assert property (p_pll_off)
    else $error("PLL running with post-divider off code");
  property p_pllsrc_clear;
    (ce && lowPowerWait) |=> !pllSrcReg;
  endproperty
  a_pllsrc_clear: assert property (p_pllsrc_clear)
    else $error("PLL source select survived low-power wait");
  property p_core_equal;
    (ce && curTick && coreRun && prescale == 3'h0) |=> coreTick && sysTick;
  endproperty
  a_core_equal: assert property (p_core_equal)
    else $error("core clock not equal to system clock at ratio one");
  property p_core_hold;
    (ce && (memWait || busReq || waitForInt)) |=> !coreTick;
  endproperty
  a_core_hold: assert property (p_core_hold)
    else $error("core clock edge during hold or wait");
  property p_alt_absent;
    (ce && !altPresent) |=> (srcReg != SRC_ALT);
  endproperty
  a_alt_absent: assert property (p_alt_absent)
    else $error("absent alternate clock in use");
  property p_xtal_stop;
    !altActive |-> oscEnable;
  endproperty
  a_xtal_stop: assert property (p_xtal_stop)
    else $error("crystal stopped without alternate clock");
  property p_irq_route;
    (ce && !intSel) |=> (irqLine == $past(extIrqPin));
  endproperty
  a_irq_route: assert property (p_irq_route)
    else $error("external pin not routed to interrupt line");
  property p_irq_fall;
    (ce && srcEvent && intSel) ##1 (ce && intSel) |=> !irqLine;
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("clock interrupt did not drive a falling edge");
  c_pll_used: cover property (srcReg == SRC_PLL);
  c_alt_used: cover property (srcReg == SRC_ALT && oscStopped);
  c_div16_wait: cover property (lowPowerWait && srcReg == SRC_DIV16);
  c_prescaled: cover property (coreTick && prescale == 3'h7);
endmodule : pll_clock_control_unit

//--- verif/clock_partner_model.sv
module clock_partner_model
#(
  parameter int OSC_PERIOD = 10,
  parameter int ALT_PERIOD = 6
)
(
  // Clock and controls
  input wire logic clk,
  input wire logic oscEnable,
  input wire logic altRun,
  // Source edges
  output logic oscTick,
  output logic altTick
);
  timeunit 1ns;
  timeprecision 100ps;

  int oscCnt = 0;
  int altCnt = 0;

  initial
  begin
    oscTick = 1'b0;
    altTick = 1'b0;
  end

  // A stopped crystal gives no edges at all, not a last level.
  always @(posedge clk)
  begin
    oscCnt <= (oscCnt + 1) % OSC_PERIOD;
    altCnt <= (altCnt + 1) % ALT_PERIOD;
    oscTick <= oscEnable && (oscCnt == 0);
    altTick <= altRun && (altCnt == 0);
  end
endmodule : clock_partner_model

//--- verif/pll_clock_control_unit_tb_top.sv
module pll_clock_control_unit_tb_top
  import clock_unit_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wrData = 8'h00;
  logic wrStrobe = 1'b0;
  logic rdStrobe = 1'b0;
  logic waitForInt = 1'b0;
  logic memWait = 1'b0;
  logic busReq = 1'b0;
  logic extIrqPin = 1'b1;
  logic altRun = 1'b0;
  logic [7:0] rdData;
  logic sysTick, coreTick, oscEnable, pllOn, irqLine, oscTick, altTick;
  logic [7:0] cfgs [4] = '{8'h26, 8'h04, 8'h33, 8'h12};
  int fails = 0;
  int checksDone = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  pll_clock_control_unit #(.ALT_LOSS_CYCLES(40)) i_dut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .oscTick(oscTick), .altTick(altTick), .waitForInt(waitForInt),
    .memWait(memWait), .busReq(busReq), .extIrqPin(extIrqPin),
    .sysTick(sysTick), .coreTick(coreTick), .oscEnable(oscEnable),
    .pllOn(pllOn), .irqLine(irqLine));

  clock_partner_model i_partner (
    .clk(clk), .oscEnable(oscEnable), .altRun(altRun),
    .oscTick(oscTick), .altTick(altTick));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checksDone++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Tick counts depend on where in the source period we start, so the
  // rates are judged within one tick either way, two for the PLL rate.
  task automatic chkIn(input string what, input int lo, input int hi,
                       input int got);
    checksDone++;
    if (got < lo || got > hi)
    begin
      fails++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chkIn

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input string what);
    @(posedge clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1;
    chk(what, exp, rdData);
  endtask : rd

  task automatic count(input int n, output int s, output int c);
    s = 0;
    c = 0;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      s += (sysTick === 1'b1);
      c += (coreTick === 1'b1);
    end
  endtask : count

  // The first group after a prescale change may be short, so the third
  // core tick closes the measured group.
  task automatic groupLen(output int n);
    int seen;
    int guard;
    seen = 0;
    guard = 0;
    n = 0;
    while (seen < 3 && guard < 1000)
    begin
      @(posedge clk);
      #1;
      guard++;
      if (seen == 2 && sysTick === 1'b1)
        n++;
      if (coreTick === 1'b1)
        seen++;
    end
  endtask : groupLen

  task automatic irqPulse();
    int t;
    t = 0;
    while (irqLine !== 1'b0 && t < 200)
    begin
      @(posedge clk);
      #1;
      t++;
    end
    chk("irq low", 8'h00, 8'(irqLine));
    repeat (IRQ_LOW_CYCLES - 1) @(posedge clk);
    #1;
    chk("irq held", 8'h00, 8'(irqLine));
    @(posedge clk);
    #1;
    chk("irq back", 8'h01, 8'(irqLine));
  endtask : irqPulse

  task automatic done(input string t);
    $display("test %s finished", t);
  endtask : done

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      fails = fails + 1;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    int s, c, n;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(MODE_ADDR, MODE_RESET, "mode");
    rd(CTL_ADDR, CTL_RESET, "control");
    rd(FLAG_ADDR, 8'h08, "flag");
    rd(PLLCFG_ADDR, 8'h07, "pllcfg");
    rd(8'h10, 8'h00, "unmapped");
    chk("pllOn", 8'h00, 8'(pllOn));
    chk("irqLine", 8'h01, 8'(irqLine));
    count(400, s, c);
    chkIn("halved", 19, 21, s);
    chkIn("core", 19, 21, c);
    wr(MODE_ADDR, 8'hC0);
    count(400, s, c);
    chkIn("unhalved", 39, 41, s);
    done("reset");
    for (int p = 0; p < 8; p++)
    begin
      wr(MODE_ADDR, 8'hC0 | (8'(p) << 2));
      groupLen(n);
      chkIn("group", p + 1, p + 1, n);
    end
    count(400, s, c);
    chkIn("periph", 39, 41, s);
    wr(MODE_ADDR, 8'hC0);
    done("prescale");
    for (int i = 0; i < 4; i++)
    begin
      wr(FLAG_ADDR, 8'h08);
      wr(PLLCFG_ADDR, cfgs[i]);
      chk("pllOn", 8'h01, 8'(pllOn));
      repeat (60) @(posedge clk);
      wr(FLAG_ADDR, 8'h09);
      rd(FLAG_ADDR, 8'h09, "pllsrc");
      count(400, s, c);
      chkIn("pll rate", 78, 82, s);
    end
    wr(PLLCFG_ADDR, 8'h07);
    chk("pll off", 8'h00, 8'(pllOn));
    rd(FLAG_ADDR, 8'h08, "pllsrc cleared");
    done("pll");
    wr(CTL_ADDR, 8'h80);
    wr(FLAG_ADDR, 8'h00);
    irqPulse();
    count(800, s, c);
    chkIn("slow", 4, 6, s);
    wr(FLAG_ADDR, 8'h08);
    irqPulse();
    wr(CTL_ADDR, 8'h81);
    wr(PLLCFG_ADDR, 8'h04);
    repeat (60) @(posedge clk);
    wr(FLAG_ADDR, 8'h09);
    @(posedge clk);
    waitForInt <= 1'b1;
    irqPulse();
    chk("lp pll", 8'h00, 8'(pllOn));
    rd(FLAG_ADDR, 8'h08, "lp flag");
    count(800, s, c);
    chkIn("lp rate", 4, 6, s);
    chk("lp core", 8'h00, 8'(c));
    @(posedge clk);
    waitForInt <= 1'b0;
    irqPulse();
    wr(CTL_ADDR, 8'h00);
    done("low power");
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk);
      {waitForInt, memWait, busReq} <= 3'b100 >> i;
      count(200, s, c);
      chk("core held", 8'h00, 8'(c));
      chkIn("sys kept", 19, 21, s);
    end
    @(posedge clk);
    {waitForInt, memWait, busReq} <= 3'b000;
    wr(PLLCFG_ADDR, 8'h07);
    done("hold");
    wr(CTL_ADDR, 8'h04);
    repeat (60) @(posedge clk);
    rd(FLAG_ADDR, 8'h08, "alt absent");
    wr(FLAG_ADDR, 8'h18);
    chk("osc kept", 8'h01, 8'(oscEnable));
    wr(FLAG_ADDR, 8'h08);
    @(posedge clk);
    altRun <= 1'b1;
    repeat (60) @(posedge clk);
    rd(FLAG_ADDR, 8'h0C, "alt active");
    count(420, s, c);
    chkIn("alt rate", 69, 71, s);
    wr(FLAG_ADDR, 8'h18);
    chk("osc stop", 8'h00, 8'(oscEnable));
    wr(FLAG_ADDR, 8'h08);
    wr(CTL_ADDR, 8'h03);
    @(posedge clk);
    waitForInt <= 1'b1;
    n = 0;
    while (oscEnable !== 1'b0 && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("wait osc stop", 8'h00, 8'(oscEnable));
    @(posedge clk);
    waitForInt <= 1'b0;
    wr(CTL_ADDR, 8'h00);
    @(posedge clk);
    extIrqPin <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("ext irq", 8'h00, 8'(irqLine));
    @(posedge clk);
    extIrqPin <= 1'b1;
    ce <= 1'b0;
    wr(MODE_ADDR, 8'hE4);
    @(posedge clk);
    ce <= 1'b1;
    rd(MODE_ADDR, 8'hC0, "frozen mode");
    done("alternate");
    tally_and_finish();
  end
endmodule : pll_clock_control_unit_tb_top
